// >>> bench/tb_wdr_timer.sv
// testbench for the watchdog refresh timer
`timescale 1ns/1ps
module tb_wdr_timer;
  import wdr_pkg::*;
  logic clk, rst, ext_reset_pin, start_sel_pin;
  wdr_sfr_req_t sfr_req;
  logic [7:0] sfr_rdata, q;
  logic wdt_status, reset_request, internal_rst, started;
  logic [7:0] adr [4] = '{WDR_ADDR_EN_ZERO, WDR_ADDR_EN_ONE, WDR_ADDR_RELOAD, WDR_ADDR_PRIO_ZERO};
  int errors = 0;
  int check_count = 0;
  int n;
  wdr_timer wdr_timer_inst (.clk(clk), .rst(rst), .ext_reset_pin(ext_reset_pin),
    .start_sel_pin(start_sel_pin), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .wdt_status(wdt_status),
    .reset_request(reset_request), .internal_rst(internal_rst), .started(started));
  wdr_core_model wdr_core_model_inst (.clk(clk), .sfr_rdata(sfr_rdata), .sfr_req(sfr_req));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    check_count++;
    if (seen !== exp)
    begin
      errors++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    wdr_core_model_inst.acc(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a);
    wdr_core_model_inst.acc(1'b0, a, 8'h00, q);
  endtask
  ////////////////////////////////////////
  task automatic t_reset();
    foreach (adr[i])
    begin
      rd(adr[i]);
      chk(q, 8'h00);
    end
    chk(started, 1'b0);
    $display("reset test done");
  endtask
  task automatic t_reload();
    wr(WDR_ADDR_RELOAD, 8'hfc);
    rd(WDR_ADDR_RELOAD);
    chk(q, 8'hfc);
    wr(WDR_ADDR_RELOAD, 8'h7c);
    rd(WDR_ADDR_RELOAD);
    chk(q, 8'h7c);
    $display("reload test done");
  endtask
  task automatic t_start();
    start_sel_pin = 1'b1;
    n = 0;
    while (started !== 1'b1 && n < 10)
    begin
      step();
      n++;
    end
    chk(started, 1'b1);
    rd(WDR_ADDR_EN_ONE);
    chk(q[6], 1'b1);
    $display("start test done");
  endtask
  task automatic t_arm();
    wr(WDR_ADDR_EN_ZERO, 8'h40);
    rd(WDR_ADDR_EN_ZERO);
    chk(q[6], 1'b1);
    repeat (12) step();
    rd(WDR_ADDR_EN_ZERO);
    chk(q[6], 1'b0);
    $display("arm timeout test done");
  endtask
  task automatic t_refresh();
    wdr_core_model_inst.refresh(0, q);
    n = 0;
    while (wdt_status !== 1'b1 && n < 7000)
    begin
      step();
      n++;
    end
    // 7c00 to 7cff is 255 steps of 24 clocks
    chk(n >= 6110 && n <= 6130, 1'b1);
    chk(reset_request, 1'b1);
    // status stands two cycles, so this read is taken just before the reset lands
    rd(WDR_ADDR_PRIO_ZERO);
    chk(q, 8'h40);
    n = 0;
    while (internal_rst !== 1'b1 && n < 8)
    begin
      step();
      n++;
    end
    chk(internal_rst, 1'b1);
    n = 0;
    while (internal_rst !== 1'b0 && n < 20)
    begin
      step();
      n++;
    end
    repeat (4) step();
    chk(started, 1'b1);
    chk(wdt_status, 1'b0);
    $display("refresh test done");
  endtask
  task automatic t_slow();
    wr(WDR_ADDR_RELOAD, 8'hfc);
    wdr_core_model_inst.refresh(0, q);
    repeat (1900) step();
    wr(WDR_ADDR_RELOAD, 8'h7c);
    n = 0;
    while (wdt_status !== 1'b1 && n < 7000)
    begin
      step();
      n++;
    end
    // 4 steps of 384 clocks before the select clears, then 251 steps of 24
    chk(n >= 6008 && n <= 6028, 1'b1);
    n = 0;
    while (internal_rst !== 1'b1 && n < 8)
    begin
      step();
      n++;
    end
    chk(internal_rst, 1'b1);
    n = 0;
    while (internal_rst !== 1'b0 && n < 20)
    begin
      step();
      n++;
    end
    repeat (4) step();
    chk(started, 1'b1);
    $display("slow prescaler test done");
  endtask
  task automatic t_ext();
    ext_reset_pin = 1'b1;
    repeat (8) step();
    chk(internal_rst, 1'b1);
    chk(started, 1'b0);
    ext_reset_pin = 1'b0;
    repeat (10) step();
    chk(started, 1'b0);
    $display("external reset test done");
  endtask
  ////////////////////////////////////////
  initial
  begin
    #1000000;
    errors++;
    finish_test();
  end
  initial
  begin
    rst = 1'b1;
    ext_reset_pin = 1'b0;
    start_sel_pin = 1'b0;
    repeat (6) @(posedge clk);
    #1 rst = 1'b0;
    step();
    t_reset();
    t_reload();
    t_start();
    t_arm();
    t_refresh();
    t_slow();
    t_ext();
    finish_test();
  end
endmodule

// >>> bench/wdr_core_model.sv
// core model issuing sfr accesses to the timer
`timescale 1ns/1ps
module wdr_core_model
  import wdr_pkg::*;
(
  // bus
  input wire logic clk,
  input wire logic [7:0] sfr_rdata,
  output wdr_sfr_req_t sfr_req
);
  initial sfr_req = '0;
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] q);
    @(posedge clk);
    #1 sfr_req = '{wr: w, rd: !w, addr: a, wdata: d};
    @(posedge clk);
    // idle lines show the inverse so stale values cannot pass
    #1 sfr_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    q = sfr_rdata;
  endtask
  // arm then confirm, gap plus one idle cycles apart
  task automatic refresh(input int gap, output logic [7:0] q);
    acc(1'b1, WDR_ADDR_EN_ZERO, 8'h40, q);
    repeat (gap) @(posedge clk);
    acc(1'b1, WDR_ADDR_EN_ONE, 8'h40, q);
  endtask
endmodule

// >>> bench/wdr_timer_props.sv
// port assertions for the watchdog refresh timer
`timescale 1ns/1ps
module wdr_timer_props
  import wdr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // pins and bus
  input wire logic ext_reset_pin,
  input wire logic start_sel_pin,
  input wire wdr_sfr_req_t sfr_req,
  input wire logic [7:0] sfr_rdata,
  // status
  input wire logic wdt_status,
  input wire logic reset_request,
  input wire logic internal_rst,
  input wire logic started
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////
  req_status_a: assert property (reset_request == wdt_status)
    else $error("reset request differs");
  wd_reset_a: assert property (reset_request ##1 reset_request |-> ##[0:3] internal_rst)
    else $error("no reset after request");
  ext_reset_a: assert property (ext_reset_pin [*6] |-> internal_rst)
    else $error("no reset after pin");
  status_clr_a: assert property (internal_rst ##1 internal_rst |-> !wdt_status)
    else $error("status held in reset");
  run_hold_a: assert property (started && !internal_rst |=> started)
    else $error("watchdog stopped");
  idle_status_a: assert property (!started |-> !wdt_status)
    else $error("status while stopped");
  prio_read_a: assert property ($past(sfr_req.rd && sfr_req.addr == WDR_ADDR_PRIO_ZERO)
    |-> sfr_rdata[WDR_PRIO_STATUS_BIT] == $past(wdt_status)) else $error("priority bit wrong");
  start_read_a: assert property ($past(sfr_req.rd && sfr_req.addr == WDR_ADDR_EN_ONE)
    |-> sfr_rdata[WDR_CONFIRM_BIT] == $past(started)) else $error("started bit wrong");
  rst_clear_a: assert property ($fell(rst) |-> !started && !wdt_status)
    else $error("not clear after reset");
  cover property ($rose(wdt_status));
  cover property ($rose(started));
  cover property (ext_reset_pin [*6]);
endmodule
bind wdr_timer wdr_timer_props wdr_timer_props_inst (.clk(clk), .rst(rst), .ext_reset_pin(ext_reset_pin),
  .start_sel_pin(start_sel_pin), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata), .wdt_status(wdt_status),
  .reset_request(reset_request), .internal_rst(internal_rst), .started(started));

// >>> rtl/wdr_pkg.sv
// package for the watchdog refresh timer: sfr map, field positions, reset values, counts
package wdr_pkg;

  // special function register addresses (8-bit sfr space)
  localparam logic [7:0] WDR_ADDR_EN_ZERO = 8'ha8;
  localparam logic [7:0] WDR_ADDR_EN_ONE = 8'hb8;
  localparam logic [7:0] WDR_ADDR_RELOAD = 8'h86;
  localparam logic [7:0] WDR_ADDR_PRIO_ZERO = 8'ha9;

  // field positions
  localparam int WDR_ARM_BIT = 6;
  localparam int WDR_CONFIRM_BIT = 6;
  localparam int WDR_PRIO_STATUS_BIT = 6;
  localparam int WDR_PRESEL_BIT = 7;

  // reset values
  localparam logic [7:0] WDR_REG_RST = 8'h00;
  localparam logic [15:0] WDR_CNT_RST = 16'h0000;

  // terminal count and timing
  localparam logic [15:0] WDR_TERMINAL = 16'h7cff;
  localparam int WDR_PRE2_DIV = 2;
  localparam int WDR_PRE16_DIV = 16;
  localparam int WDR_BASE_DIV = 12;
  localparam logic [3:0] WDR_ARM_WINDOW = 4'hc;
  localparam logic [1:0] WDR_RST_HOLD = 2'h2;
  localparam logic [3:0] WDR_BASE_LAST = 4'(WDR_BASE_DIV - 1);
  localparam logic [3:0] WDR_PRE16_LAST = 4'(WDR_PRE16_DIV - 1);

  // one sfr write or read request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } wdr_sfr_req_t;

endpackage

// >>> rtl/wdr_prescale.sv
// prescaler chain: 12-cycle base, divide by 2, optional divide by 16
`timescale 1ns/1ps
module wdr_prescale
  import wdr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // control
  input wire logic run,
  input wire logic sel16,
  input wire logic restart,
  // tick out
  output logic tick
);

  logic [3:0] base_r, base_nxt;
  logic half_r, half_nxt;
  logic [3:0] p16_r, p16_nxt;
  logic base_en;
  logic half_en;

  always_comb
  begin
    base_en = run && (base_r == WDR_BASE_LAST);
    half_en = base_en && half_r;
    base_nxt = base_r;
    half_nxt = half_r;
    p16_nxt = p16_r;
    if (restart || !run)
    begin
      base_nxt = 4'h0;
      half_nxt = 1'b0;
      p16_nxt = 4'h0;
    end
    else
    begin
      base_nxt = base_en ? 4'h0 : base_r + 4'h1;
      if (base_en)
        half_nxt = ~half_r;
      if (half_en)
        p16_nxt = p16_r + 4'h1;
    end
    // 12 x 2 = 24, or 24 x 16 = 384 clocks per count
    tick = sel16 ? (half_en && (p16_r == WDR_PRE16_LAST)) : half_en;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      base_r <= 4'h0;
      half_r <= 1'b0;
      p16_r <= 4'h0;
    end
    else
    begin
      base_r <= base_nxt;
      half_r <= half_nxt;
      p16_r <= p16_nxt;
    end
  end

endmodule

// >>> rtl/wdr_timer.sv
// watchdog refresh timer: counter, arm/confirm refresh, status and reset request
// Function
// - 16-bit up-counter advancing every 24 clocks, or 384 with extra prescaler.
// - count path is divide-by-2 plus optional divide-by-16 prescaler.
// - external reset leaves watchdog disabled, counter and registers zero.
// - start-select level sampled during a watchdog reset starts watchdog automatically.
// - otherwise watchdog starts when start-select later becomes active.
// - a running watchdog stops only on internal reset.
// - counter at 7cffh asserts status combinationally.
// - status sets priority register bit 6 and requests device reset.
// - status clears on internal reset or when counter leaves terminal value.
// - confirm within 12 clocks of arm, else arm clears with no reload.
// - timely confirm reloads counter and clears arm bit.
// - arm bit is enable register zero bit 6, hardware-cleared after 12 cycles.
// - reload bit 7 selects divide-by-16; bits 6-0 are high-byte reload value.
// - confirm is enable register one bit 6; read returns started flag.
// - reset source held two clocks resets the device.
// - reload register readable and writable at any time.
`timescale 1ns/1ps
module wdr_timer
  import wdr_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // external reset and start-select pins
  input wire logic ext_reset_pin,
  input wire logic start_sel_pin,
  // sfr port from the core
  input wire wdr_sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // status and reset
  output logic wdt_status,
  output logic reset_request,
  output logic internal_rst,
  output logic started
);

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers

  logic [1:0] ext_sync_r, ext_sync_nxt;
  logic [1:0] swd_sync_r, swd_sync_nxt;
  logic ext_lvl;
  logic swd_lvl;

  always_comb
  begin
    ext_sync_nxt = {ext_sync_r[0], ext_reset_pin};
    swd_sync_nxt = {swd_sync_r[0], start_sel_pin};
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_sync_r <= 2'h0;
      swd_sync_r <= 2'h0;
    end
    else
    begin
      ext_sync_r <= ext_sync_nxt;
      swd_sync_r <= swd_sync_nxt;
    end
  end

  assign ext_lvl = ext_sync_r[1];
  assign swd_lvl = swd_sync_r[1];

  ////////////////////////////////////////////////////////////////////////////
  // internal reset generation

  logic [1:0] ext_hold_r, ext_hold_nxt;
  logic [1:0] req_hold_r, req_hold_nxt;
  logic irst_r, irst_nxt;
  logic ext_seen_r, ext_seen_nxt;

  always_comb
  begin
    ext_hold_nxt = ext_lvl ? ((ext_hold_r == WDR_RST_HOLD) ? ext_hold_r : ext_hold_r + 2'h1) : 2'h0;
    req_hold_nxt = reset_request ? ((req_hold_r == WDR_RST_HOLD) ? req_hold_r : req_hold_r + 2'h1) : 2'h0;
    // a source held two clocks drives internal reset
    irst_nxt = (ext_hold_nxt == WDR_RST_HOLD) || (req_hold_nxt == WDR_RST_HOLD);
    ext_seen_nxt = ext_seen_r;
    if (ext_hold_nxt == WDR_RST_HOLD)
      ext_seen_nxt = 1'b1;
    else if (!irst_r)
      ext_seen_nxt = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      ext_hold_r <= 2'h0;
      req_hold_r <= 2'h0;
      irst_r <= 1'b1;
      ext_seen_r <= 1'b1;
    end
    else
    begin
      ext_hold_r <= ext_hold_nxt;
      req_hold_r <= req_hold_nxt;
      irst_r <= irst_nxt;
      ext_seen_r <= ext_seen_nxt;
    end
  end

  assign internal_rst = irst_r || rst;

  ////////////////////////////////////////////////////////////////////////////
  // start control, registers, refresh sequence

  typedef enum logic [1:0] {WDR_IDLE, WDR_RUN} wdr_state_t;

  wdr_state_t state_r, state_nxt;
  logic auto_r, auto_nxt;
  logic swd_prev_r, swd_prev_nxt;
  logic [7:0] reload_r, reload_nxt;
  logic [7:0] en_zero_other_r, en_zero_other_nxt;
  logic [7:0] en_one_other_r, en_one_other_nxt;
  logic [7:0] prio_zero_other_r, prio_zero_other_nxt;
  logic arm_r, arm_nxt;
  logic [3:0] arm_cnt_r, arm_cnt_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  // one-cycle count enable from the prescaler chain
  logic tick;
  logic refresh;
  logic wr_en_zero;
  logic wr_en_one;

  function automatic logic sfr_hit(input wdr_sfr_req_t req, input logic [7:0] addr);
    sfr_hit = req.wr && (req.addr == addr);
  endfunction

  always_comb
  begin
    wr_en_zero = sfr_hit(sfr_req, WDR_ADDR_EN_ZERO);
    wr_en_one = sfr_hit(sfr_req, WDR_ADDR_EN_ONE);
    state_nxt = state_r;
    auto_nxt = auto_r;
    swd_prev_nxt = swd_lvl;
    reload_nxt = reload_r;
    en_zero_other_nxt = en_zero_other_r;
    en_one_other_nxt = en_one_other_r;
    prio_zero_other_nxt = prio_zero_other_r;
    arm_nxt = arm_r;
    arm_cnt_nxt = arm_cnt_r;
    cnt_nxt = cnt_r;
    refresh = 1'b0;
    if (irst_r)
    begin
      // everything cleared; a watchdog reset keeps the start-select capture
      state_nxt = WDR_IDLE;
      auto_nxt = swd_lvl && !ext_seen_r;
      reload_nxt = WDR_REG_RST;
      en_zero_other_nxt = WDR_REG_RST;
      en_one_other_nxt = WDR_REG_RST;
      prio_zero_other_nxt = WDR_REG_RST;
      arm_nxt = 1'b0;
      arm_cnt_nxt = 4'h0;
      cnt_nxt = WDR_CNT_RST;
    end
    else
    begin
      case (state_r)
        WDR_IDLE:
        begin
          if (auto_r)
            state_nxt = WDR_RUN;
          else if (swd_lvl && !swd_prev_r)
            state_nxt = WDR_RUN;
        end
        WDR_RUN:
          state_nxt = WDR_RUN;
        default:
          state_nxt = WDR_IDLE;
      endcase
      if (sfr_hit(sfr_req, WDR_ADDR_RELOAD))
        reload_nxt = sfr_req.wdata;
      // bits that do not belong to the watchdog are plain storage
      if (wr_en_zero)
        en_zero_other_nxt = sfr_req.wdata;
      if (wr_en_one)
        en_one_other_nxt = sfr_req.wdata;
      if (sfr_hit(sfr_req, WDR_ADDR_PRIO_ZERO))
        prio_zero_other_nxt = sfr_req.wdata;
      // confirm while armed reloads and disarms
      if (arm_r && wr_en_one && sfr_req.wdata[WDR_CONFIRM_BIT])
      begin
        refresh = 1'b1;
        arm_nxt = 1'b0;
        arm_cnt_nxt = 4'h0;
      end
      else if (wr_en_zero && sfr_req.wdata[WDR_ARM_BIT])
      begin
        arm_nxt = 1'b1;
        arm_cnt_nxt = 4'h0;
      end
      else if (arm_r)
      begin
        // window expiry disarms without reload
        arm_cnt_nxt = arm_cnt_r + 4'h1;
        if (arm_cnt_nxt == WDR_ARM_WINDOW)
          arm_nxt = 1'b0;
      end
      if (refresh)
        cnt_nxt = {1'b0, reload_r[6:0], 8'h00};
      else if (state_r == WDR_RUN && tick)
        cnt_nxt = cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_r <= WDR_IDLE;
      auto_r <= 1'b0;
      swd_prev_r <= 1'b0;
      reload_r <= WDR_REG_RST;
      en_zero_other_r <= WDR_REG_RST;
      en_one_other_r <= WDR_REG_RST;
      prio_zero_other_r <= WDR_REG_RST;
      arm_r <= 1'b0;
      arm_cnt_r <= 4'h0;
      cnt_r <= WDR_CNT_RST;
    end
    else
    begin
      state_r <= state_nxt;
      auto_r <= auto_nxt;
      swd_prev_r <= swd_prev_nxt;
      reload_r <= reload_nxt;
      en_zero_other_r <= en_zero_other_nxt;
      en_one_other_r <= en_one_other_nxt;
      prio_zero_other_r <= prio_zero_other_nxt;
      arm_r <= arm_nxt;
      arm_cnt_r <= arm_cnt_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // prescale chain is restarted on refresh so each reload gives a full period
  wdr_prescale wdr_prescale_inst (
    .clk(clk),
    .rst(rst),
    .run(state_r == WDR_RUN && !irst_r),
    .sel16(reload_r[WDR_PRESEL_BIT]),
    .restart(refresh),
    .tick(tick)
  );

  ////////////////////////////////////////////////////////////////////////////
  // status, reset request and readback

  always_comb
  begin
    // decoded straight from the count, so it drops as soon as the count moves
    wdt_status = (state_r == WDR_RUN) && !irst_r && (cnt_r == WDR_TERMINAL);
    reset_request = wdt_status;
    started = (state_r == WDR_RUN);
  end

  logic [7:0] rdata_nxt;

  always_comb
  begin
    rdata_nxt = 8'h00;
    if (sfr_req.rd)
    begin
      case (sfr_req.addr)
        WDR_ADDR_EN_ZERO:
        begin
          rdata_nxt = en_zero_other_r;
          rdata_nxt[WDR_ARM_BIT] = arm_r;
        end
        WDR_ADDR_EN_ONE:
        begin
          rdata_nxt = en_one_other_r;
          rdata_nxt[WDR_CONFIRM_BIT] = started;
        end
        WDR_ADDR_PRIO_ZERO:
        begin
          rdata_nxt = prio_zero_other_r;
          rdata_nxt[WDR_PRIO_STATUS_BIT] = wdt_status;
        end
        WDR_ADDR_RELOAD:
          rdata_nxt = reload_r;
        default:
          rdata_nxt = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      sfr_rdata <= 8'h00;
    else
      sfr_rdata <= rdata_nxt;
  end

endmodule
